// File: design/btwu_top.sv
// Command logic for time limits, trigger, event wait and data write.
`timescale 1ns/1ns
`include "btwu_consts.svh"
module btwu_top import btwu_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Parsed command
  input  wire logic        cmdValid,
  input  wire logic [2:0]  cmdCode,
  input  wire logic        argAValid,
  input  wire logic [31:0] argA,
  input  wire logic        argBValid,
  input  wire logic [31:0] argB,
  input  wire logic        argList,
  output logic             cmdReady,
  // Configuration
  input  wire logic        sysCtrlEnable,
  input  wire logic        statCont,
  input  wire logic        statNum,
  input  wire logic        statSym,
  input  wire logic        serialErr,
  // Bus side
  input  wire logic [15:0] busStatus,
  input  wire logic        ctrlPassed,
  input  wire logic        trgDone,
  input  wire logic        spResp,
  output logic             ifcOut,
  output logic             renOut,
  output logic             trgReq,
  output logic             ioAbort,
  output logic             spError,
  // Write data
  input  wire logic        hostByteValid,
  input  wire logic [7:0]  hostByte,
  output logic             hostByteReady,
  output logic             busByteValid,
  output logic [7:0]       busByte,
  input  wire logic        busByteReady,
  output logic [31:0]      wrtCount,
  // Replies
  output logic             replyValid,
  output logic [1:0]       replyKind,
  output logic [15:0]      replyStatus,
  output logic [4:0]       errCode,
  output logic [28:0]      limIo,
  output logic [28:0]      limSp
);
  localparam btwu_regs_s RESET_VAL = '{
    st: S_IDLE, ioLim: 29'(`BTWU_TIO_DEF), spLim: 29'(`BTWU_TSP_DEF),
    repKind: REP_NUM, cmdRdy: 1'b1, default: '0};

  btwu_regs_s  rReg;
  btwu_regs_s  rNext;
  logic        tick;
  logic        accept;
  logic        hostTake;
  logic        busTake;
  logic        waitHit;
  logic        bothFmt;
  logic [15:0] statusNow;

  btwu_timer_if ioT ();
  btwu_timer_if spT ();

  function automatic logic inRange(input logic [31:0] v);
    return v <= 32'(`BTWU_TMAX);
  endfunction

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  btwu_tick u_tick (.clk(clk), .arst_n(arst_n), .tick(tick));
  btwu_timer u_io (.clk(clk), .arst_n(arst_n), .tick(tick), .t(ioT));
  btwu_timer u_sp (.clk(clk), .arst_n(arst_n), .tick(tick), .t(spT));

  assign ioT.limit = rReg.ioLim;
  assign ioT.run   = (rReg.st == S_WRITE)
                     || (rReg.st == S_WAIT && rReg.mask[`BTWU_BIT_TIMEOUT]);
  assign spT.limit = rReg.spLim;
  assign spT.run   = (rReg.st == S_POLL);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  assign accept    = cmdValid && rReg.cmdRdy;
  assign hostTake  = rReg.hostRdy && hostByteValid;
  assign busTake   = rReg.busVld && busByteReady;
  assign waitHit   = |(busStatus & rReg.mask & `BTWU_MASK_EVENTS);
  assign bothFmt   = statCont && statNum && statSym;
  assign statusNow = {(rReg.err != `BTWU_ERR_NONE) || serialErr,
                      rReg.timedOut, busStatus[13:0]};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    rNext         = rReg;
    rNext.repVld  = 1'b0;
    rNext.ioAbort = 1'b0;
    rNext.spErr   = 1'b0;
    case (rReg.st)
      S_IDLE: begin
        if (accept) begin
          rNext.err      = `BTWU_ERR_NONE;
          rNext.timedOut = 1'b0;
          rNext.st       = S_DONE;
          case (cmdCode)
            BTWU_TMO: begin
              if (!argAValid && !argBValid) begin
                rNext.repVld  = 1'b1;
                rNext.repKind = REP_LIM;
              end else if ((argAValid && !inRange(argA))
                           || (argBValid && !inRange(argB))) begin
                rNext.err = `BTWU_ERR_ARG;
              end else begin
                if (argAValid) begin
                  rNext.ioLim = argA[28:0];
                end
                if (argBValid) begin
                  rNext.spLim = argB[28:0];
                end
              end
            end
            BTWU_ONL: begin
              rNext.ioLim    = RESET_VAL.ioLim;
              rNext.spLim    = RESET_VAL.spLim;
              rNext.ctrlUsed = 1'b0;
              rNext.ren      = 1'b0;
            end
            BTWU_TRG: begin
              if (!argList) begin
                rNext.err = `BTWU_ERR_ARG;
              end else if (!rReg.ctrlUsed && sysCtrlEnable) begin
                rNext.ctrlUsed = 1'b1;
                rNext.ifc      = 1'b1;
                rNext.ren      = 1'b1;
                rNext.ifcCnt   = 4'h0;
                rNext.st       = S_IFC;
              end else if (ctrlPassed) begin
                rNext.err = `BTWU_ERR_NOTCTRL;
              end else begin
                rNext.trg = 1'b1;
                rNext.st  = S_TRIG;
              end
            end
            BTWU_WAIT: begin
              rNext.mask = argA[15:0];
              if (!argAValid) begin
                rNext.err = `BTWU_ERR_ARG;
              end else if (argA[15:0] == 16'h0000) begin
                rNext.st = S_REPORT;
              end else begin
                rNext.st = S_WAIT;
              end
            end
            BTWU_WRT: begin
              rNext.cntMode = argAValid;
              rNext.remain  = argA;
              rNext.term    = argAValid && (argA == 32'h0);
              rNext.wrCount = 32'h0;
              rNext.st      = S_WRITE;
            end
            BTWU_RSP: begin
              rNext.st = S_POLL;
            end
            default: begin
              rNext.st = S_DONE;
            end
          endcase
        end
      end
      S_DONE: begin
        rNext.st = statCont ? S_REPORT : S_IDLE;
      end
      S_REPORT: begin
        rNext.repVld    = 1'b1;
        rNext.repStatus = statusNow;
        rNext.repKind   = (statCont && statSym && !statNum) ? REP_SYM : REP_NUM;
        rNext.st        = bothFmt ? S_REP_SYM : S_IDLE;
      end
      S_REP_SYM: begin
        rNext.repVld    = 1'b1;
        rNext.repStatus = statusNow;
        rNext.repKind   = REP_SYM;
        rNext.st        = S_IDLE;
      end
      S_WAIT: begin
        if (ioT.expired) begin
          rNext.timedOut = 1'b1;
          rNext.st       = S_REPORT;
        end else if (waitHit) begin
          rNext.st = S_REPORT;
        end
      end
      S_IFC: begin
        if (tick) begin
          rNext.ifcCnt = rReg.ifcCnt + 4'h1;
          if (rReg.ifcCnt == 4'(`BTWU_IFC_TICKS - 1)) begin
            rNext.ifc = 1'b0;
            rNext.trg = 1'b1;
            rNext.st  = S_TRIG;
          end
        end
      end
      S_TRIG: begin
        if (trgDone) begin
          rNext.trg = 1'b0;
          rNext.st  = S_DONE;
        end
      end
      S_POLL: begin
        if (spResp) begin
          rNext.st = S_DONE;
        end else if (spT.expired) begin
          rNext.spErr = 1'b1;
          rNext.err   = `BTWU_ERR_ABORT;
          rNext.st    = S_DONE;
        end
      end
      S_WRITE: begin
        if (busTake) begin
          rNext.busVld  = 1'b0;
          rNext.wrCount = rReg.wrCount + 32'h1;
        end
        if (hostTake) begin
          if (!rReg.cntMode && hostByte == `BTWU_CHAR_CR) begin
            rNext.term = 1'b1;
          end else begin
            rNext.busVld  = 1'b1;
            rNext.busByte = hostByte;
            rNext.remain  = rReg.remain - 32'h1;
            rNext.term    = rReg.cntMode && (rReg.remain == 32'h1);
          end
        end
        if (ioT.expired) begin
          rNext.ioAbort = 1'b1;
          rNext.err     = `BTWU_ERR_ABORT;
          rNext.busVld  = 1'b0;
          rNext.st      = rNext.term ? S_DONE : S_DRAIN;
        end else if (rNext.term && !rNext.busVld) begin
          rNext.st = S_DONE;
        end
      end
      S_DRAIN: begin
        if (hostTake) begin
          rNext.remain = rReg.remain - 32'h1;
          if (rReg.cntMode ? (rReg.remain == 32'h1) : (hostByte == `BTWU_CHAR_CR)) begin
            rNext.st = S_DONE;
          end
        end
      end
      default: begin
        rNext.st = S_IDLE;
      end
    endcase
    rNext.cmdRdy  = (rNext.st == S_IDLE);
    rNext.hostRdy = (rNext.st == S_WRITE && !rNext.busVld && !rNext.term)
                    || (rNext.st == S_DRAIN);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rReg <= RESET_VAL;
    end else begin
      rReg <= rNext;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmdReady      = rReg.cmdRdy;
  assign ifcOut        = rReg.ifc;
  assign renOut        = rReg.ren;
  assign trgReq        = rReg.trg;
  assign ioAbort       = rReg.ioAbort;
  assign spError       = rReg.spErr;
  assign hostByteReady = rReg.hostRdy;
  assign busByteValid  = rReg.busVld;
  assign busByte       = rReg.busByte;
  assign wrtCount      = rReg.wrCount;
  assign replyValid    = rReg.repVld;
  assign replyKind     = rReg.repKind;
  assign replyStatus   = rReg.repStatus;
  assign errCode       = rReg.err;
  assign limIo         = rReg.ioLim;
  assign limSp         = rReg.spLim;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_tmo_query;
    accept && cmdCode == BTWU_TMO && !argAValid && !argBValid
      |=> replyValid && replyKind == REP_LIM && $stable(limIo);
  endproperty
  a_tmo_query: assert property (p_tmo_query) else $error("Limit query lost.");
  property p_tmo_range;
    accept && cmdCode == BTWU_TMO && argAValid && !inRange(argA)
      |=> errCode == `BTWU_ERR_ARG && $stable(limIo) && $stable(limSp);
  endproperty
  a_tmo_range: assert property (p_tmo_range) else $error("Bad limit taken.");
  property p_tmo_comma;
    accept && cmdCode == BTWU_TMO && !argAValid && argBValid && inRange(argB)
      |=> $stable(limIo) && limSp == $past(argB[28:0]);
  endproperty
  a_tmo_comma: assert property (p_tmo_comma) else $error("Poll-only set wrong.");
  property p_trg_empty;
    accept && cmdCode == BTWU_TRG && !argList
      |=> errCode == `BTWU_ERR_ARG && !trgReq ##1 !trgReq && !ifcOut;
  endproperty
  a_trg_empty: assert property (p_trg_empty) else $error("Empty trigger acted.");
  property p_ifc;
    accept && cmdCode == BTWU_TRG && argList && !rReg.ctrlUsed && sysCtrlEnable
      |=> (ifcOut && renOut && !trgReq) [*8];
  endproperty
  a_ifc: assert property (p_ifc) else $error("Clear pulse missing.");
  property p_notctrl;
    accept && cmdCode == BTWU_TRG && argList && ctrlPassed
      && (rReg.ctrlUsed || !sysCtrlEnable)
      |=> errCode == `BTWU_ERR_NOTCTRL && !trgReq && !ifcOut;
  endproperty
  a_notctrl: assert property (p_notctrl) else $error("Control error missing.");
  property p_mask0;
    accept && cmdCode == BTWU_WAIT && argAValid && argA[15:0] == 16'h0000
      |=> !replyValid ##1 replyValid && replyKind != REP_LIM;
  endproperty
  a_mask0: assert property (p_mask0) else $error("Zero mask did not return.");
  property p_wait_noarg;
    accept && cmdCode == BTWU_WAIT && !argAValid |=> errCode == `BTWU_ERR_ARG;
  endproperty
  a_wait_noarg: assert property (p_wait_noarg) else $error("Missing mask taken.");
  property p_num_first;
    rReg.st == S_REPORT && bothFmt
      |=> replyValid && replyKind == REP_NUM ##1 replyValid && replyKind == REP_SYM;
  endproperty
  a_num_first: assert property (p_num_first) else $error("Status order wrong.");
  property p_abort;
    ioAbort |-> errCode == `BTWU_ERR_ABORT && !busByteValid
      && wrtCount == $past(wrtCount) + {31'h0, $past(busTake)};
  endproperty
  a_abort: assert property (p_abort) else $error("Abort state wrong.");

  c_ifc: cover property (ifcOut ##1 !ifcOut ##[1:4] trgReq);
  c_wait_timeout: cover property (replyValid && replyStatus[`BTWU_BIT_TIMEOUT]);
  c_abort: cover property (ioAbort);
  c_poll_err: cover property (spError);
endmodule // btwu_top

// File: design/btwu_consts.svh
// Constants for the timeout, trigger and wait unit.
`ifndef BTWU_CONSTS_SVH
`define BTWU_CONSTS_SVH
`define BTWU_CLK_NS       20
`define BTWU_TICK_NS      10000
`define BTWU_TICK_CYC     (`BTWU_TICK_NS / `BTWU_CLK_NS)
`define BTWU_TICKS_PER_S  (1000000000 / `BTWU_TICK_NS)
`define BTWU_TIO_DEF_S    10
`define BTWU_TSP_DEF_MS   100
`define BTWU_TMAX_S       3600
`define BTWU_TIFC_US      100
`define BTWU_TIO_DEF      (`BTWU_TIO_DEF_S * `BTWU_TICKS_PER_S)
`define BTWU_TSP_DEF      (`BTWU_TSP_DEF_MS * `BTWU_TICKS_PER_S / 1000)
`define BTWU_TMAX         (`BTWU_TMAX_S * `BTWU_TICKS_PER_S)
`define BTWU_IFC_TICKS    (`BTWU_TIFC_US * 1000 / `BTWU_TICK_NS)
`define BTWU_ERR_NONE     5'h00
`define BTWU_ERR_NOTCTRL  5'h01
`define BTWU_ERR_ARG      5'h04
`define BTWU_ERR_ABORT    5'h06
`define BTWU_BIT_TIMEOUT  14
`define BTWU_MASK_EVENTS  16'h30ff
`define BTWU_CHAR_CR      8'h0d
`endif

// File: design/btwu_pkg.sv
// Types for the timeout, trigger and wait unit.
package btwu_pkg;
  typedef enum logic [2:0] {
    BTWU_TMO = 3'h0, BTWU_TRG = 3'h1, BTWU_WAIT = 3'h2,
    BTWU_WRT = 3'h3, BTWU_RSP = 3'h4, BTWU_ONL = 3'h5
  } btwu_cmd_e;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_DONE = 4'h1, S_REPORT = 4'h2, S_REP_SYM = 4'h3,
    S_WAIT = 4'h4, S_IFC = 4'h5, S_TRIG = 4'h6, S_POLL = 4'h7,
    S_WRITE = 4'h8, S_DRAIN = 4'h9
  } btwu_state_e;
  typedef enum logic [1:0] {REP_NUM = 2'h0, REP_SYM = 2'h1, REP_LIM = 2'h2} btwu_rep_e;
  typedef logic [28:0] btwu_lim_t;
  typedef struct packed {
    btwu_state_e st;
    btwu_lim_t   ioLim;
    btwu_lim_t   spLim;
    logic [4:0]  err;
    logic        timedOut;
    logic [15:0] mask;
    logic        ctrlUsed;
    logic        ifc;
    logic        ren;
    logic        trg;
    logic [3:0]  ifcCnt;
    logic        cntMode;
    logic        term;
    logic [31:0] remain;
    logic [31:0] wrCount;
    logic        hostRdy;
    logic        busVld;
    logic [7:0]  busByte;
    logic        repVld;
    btwu_rep_e   repKind;
    logic [15:0] repStatus;
    logic        ioAbort;
    logic        spErr;
    logic        cmdRdy;
  } btwu_regs_s;
endpackage

// File: design/btwu_timer_if.sv
// Interface between the command logic and one timeout counter.
`timescale 1ns/1ns
interface btwu_timer_if;
  btwu_pkg::btwu_lim_t limit;
  logic                run;
  logic                expired;
  modport ctrl  (output limit, output run, input expired);
  modport timer (input limit, input run, output expired);
endinterface

// File: design/btwu_tick.sv
// Prescaler that pulses once every timeout tick.
`timescale 1ns/1ns
`include "btwu_consts.svh"
module btwu_tick (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Tick
  output logic      tick
);
  logic [8:0] cntReg;
  logic       tickReg;
  logic       wrap;

  assign wrap = (cntReg == 9'(`BTWU_TICK_CYC - 1));
  assign tick = tickReg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cntReg  <= 9'h000;
      tickReg <= 1'b0;
    end else begin
      cntReg  <= wrap ? 9'h000 : cntReg + 9'h001;
      tickReg <= wrap;
    end
  end
endmodule // btwu_tick

// File: design/btwu_timer.sv
// Timeout counter that runs while its operation lasts.
`timescale 1ns/1ns
module btwu_timer import btwu_pkg::*; (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Tick and control
  input  wire logic tick,
  btwu_timer_if.timer t
);
  logic [28:0] cntReg;
  logic        doneReg;
  logic        expReg;
  logic        hit;

  // A zero limit never expires.
  assign hit = t.run && tick && !doneReg && (t.limit != 29'h0)
               && (cntReg + 29'h1 == t.limit);
  assign t.expired = expReg;

  // The count clears whenever the operation is not running.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cntReg  <= 29'h0;
      doneReg <= 1'b0;
      expReg  <= 1'b0;
    end else if (!t.run) begin
      cntReg  <= 29'h0;
      doneReg <= 1'b0;
      expReg  <= 1'b0;
    end else begin
      expReg  <= hit;
      doneReg <= doneReg | hit;
      if (tick && !doneReg) begin
        cntReg <= cntReg + 29'h1;
      end
    end
  end
endmodule // btwu_timer

// File: verification/btwu_bus_model.sv
// Far-side bus engine model that ends triggers and takes write bytes.
`timescale 1ns/1ns
module btwu_bus_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Commanded stall
  input  wire logic hold,
  // Bus engine
  input  wire logic trgReq,
  input  wire logic busByteValid,
  output logic      trgDone,
  output logic      busByteReady
);
  logic [1:0] phase;
  // Triggers end late and bytes are taken with stalls between them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase        <= 2'h0;
      trgDone      <= 1'b0;
      busByteReady <= 1'b0;
    end else begin
      phase        <= phase + 2'h1;
      trgDone      <= trgReq && !trgDone && phase == 2'h3;
      busByteReady <= busByteValid && !busByteReady && !hold && phase != 2'h0;
    end
  end
endmodule // btwu_bus_model

// File: verification/testbench.sv
// Self-checking bench for the timeout, trigger and wait unit.
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0, arst_n = 1'b0, cmdValid = 1'b0, argAValid = 1'b0, argBValid = 1'b0;
  logic        argList = 1'b0, sysCtrlEnable = 1'b1, statCont = 1'b0, statNum = 1'b0;
  logic        statSym = 1'b0, serialErr = 1'b0, ctrlPassed = 1'b0, spResp = 1'b0;
  logic        hostByteValid = 1'b0, hold = 1'b0;
  logic [2:0]  cmdCode = 3'h0;
  logic [31:0] argA = 32'h0, argB = 32'h0;
  logic [15:0] busStatus = 16'h0;
  logic [7:0]  hostByte = 8'h0;
  logic        cmdReady, trgDone, ifcOut, renOut, trgReq, ioAbort, spError, hostByteReady;
  logic        busByteValid, busByteReady, replyValid;
  logic [7:0]  busByte, b;
  logic [31:0] wrtCount;
  logic [1:0]  replyKind;
  logic [15:0] replyStatus;
  logic [4:0]  errCode;
  logic [28:0] limIo, limSp;
  logic [17:0] r;
  logic [17:0] rq[$];
  logic [7:0]  bq[$], sq[$];
  int badCount = 0, checked = 0, seed = 6803, cyc = 0, nIfc = 0, nTrg = 0, nAb = 0, nSp = 0;
  int n, t0, lio = 1000000, lsp = 10000, eErr;
  int evb[10] = '{13, 12, 7, 6, 5, 4, 3, 2, 1, 0};

  always #10 clk = ~clk;

  btwu_top dut (
    .clk, .arst_n, .cmdValid, .cmdCode, .argAValid, .argA, .argBValid, .argB, .argList,
    .cmdReady, .sysCtrlEnable, .statCont, .statNum, .statSym, .serialErr, .busStatus,
    .ctrlPassed, .trgDone, .spResp, .ifcOut, .renOut, .trgReq, .ioAbort, .spError,
    .hostByteValid, .hostByte, .hostByteReady, .busByteValid, .busByte, .busByteReady,
    .wrtCount, .replyValid, .replyKind, .replyStatus, .errCode, .limIo, .limSp
  );
  btwu_bus_model model (.clk, .arst_n, .hold, .trgReq, .busByteValid, .trgDone, .busByteReady);

  // ----------------------------------------
  // Monitors and helpers.
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (replyValid === 1'b1) rq.push_back({replyKind, replyStatus});
    if (busByteValid === 1'b1 && busByteReady === 1'b1) bq.push_back(busByte);
    if (ifcOut === 1'b1) nIfc++;
    if (trgReq === 1'b1) nTrg++;
    if (ioAbort === 1'b1) nAb++;
    if (spError === 1'b1) nSp++;
    if (cyc == 30000) begin
      badCount++;
      completeRun();
    end
  end

  task automatic completeRun;
    if (badCount == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      badCount++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic cmd(logic [2:0] c, logic av, logic [31:0] a, logic bv, logic [31:0] bb);
    rq.delete();
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    argAValid <= av;
    argA <= a;
    argBValid <= bv;
    argB <= bb;
    @(posedge clk);
    while (cmdReady !== 1'b1) @(posedge clk);
    cmdValid <= 1'b0;
  endtask

  task automatic done;
    @(posedge clk);
    while (cmdReady !== 1'b1) @(posedge clk);
  endtask

  task automatic rep;
    while (rq.size() == 0) @(posedge clk);
    r = rq.pop_front();
  endtask

  task automatic hb(logic [7:0] v);
    @(posedge clk);
    hostByteValid <= 1'b1;
    hostByte <= v;
    @(posedge clk);
    while (hostByteReady !== 1'b1) @(posedge clk);
    hostByteValid <= 1'b0;
  endtask

  task automatic tmo(logic av, int a, logic bv, int bb);
    cmd(3'h0, av, a, bv, bb);
    done;
    eErr = 0;
    if ((av && a > 360000000) || (bv && bb > 360000000)) eErr = 4;
    else begin
      if (av) lio = a;
      if (bv) lsp = bb;
    end
    chk("errCode", eErr, errCode);
    chk("limIo", lio, limIo);
    chk("limSp", lsp, limSp);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk("limIo", 32'd1000000, limIo);
    chk("limSp", 32'd10000, limSp);
    tmo(1'b0, 0, 1'b0, 0);
    rep;
    chk("replyKind", 32'h2, r[17:16]);
    tmo(1'b1, 360000001, 1'b0, 0);
    tmo(1'b1, 360000000, 1'b1, 1);
    tmo(1'b0, 0, 1'b1, 7);
    tmo(1'b1, 0, 1'b1, 0);
    tmo(1'b1, 2, 1'b1, 2);
    cmd(3'h1, 1'b0, 32'h0, 1'b0, 32'h0);
    done;
    chk("errCode", 32'h4, errCode);
    chk("trgReq", 32'h0, nTrg);
    argList <= 1'b1;
    cmd(3'h1, 1'b0, 32'h0, 1'b0, 32'h0);
    done;
    chk("ifcLength", 32'h1, nIfc >= 4500 && nIfc <= 5500);
    chk("renOut", 32'h1, renOut);
    chk("trgReq", 32'h1, nTrg > 0);
    ctrlPassed <= 1'b1;
    cmd(3'h1, 1'b0, 32'h0, 1'b0, 32'h0);
    done;
    chk("errCode", 32'h1, errCode);
    ctrlPassed <= 1'b0;
    cmd(3'h2, 1'b0, 32'h0, 1'b0, 32'h0);
    done;
    chk("errCode", 32'h4, errCode);
    serialErr <= 1'b1;
    busStatus <= 16'($random(seed));
    cmd(3'h2, 1'b1, 32'h0, 1'b0, 32'h0);
    rep;
    chk("replyStatus", {2'b10, busStatus[13:0]}, r[15:0]);
    serialErr <= 1'b0;
    done;
    foreach (evb[i]) begin
      busStatus <= 16'($random(seed)) & 16'h0f00;
      cmd(3'h2, 1'b1, 32'h1 << evb[i], 1'b0, 32'h0);
      repeat (20) @(posedge clk);
      chk("earlyReply", 32'h0, rq.size());
      busStatus[evb[i]] <= 1'b1;
      rep;
      chk("replyStatus", {2'b00, busStatus[13:0]}, r[15:0]);
      chk("replyKind", 32'h0, r[17:16]);
      done;
    end
    busStatus <= 16'h0;
    t0 = cyc;
    cmd(3'h2, 1'b1, 32'd20480, 1'b0, 32'h0);
    rep;
    chk("timeoutBit", 32'h1, r[14]);
    chk("waitLength", 32'h1, cyc - t0 >= 500 && cyc - t0 <= 1100);
    done;
    tmo(1'b1, 0, 1'b0, 0);
    cmd(3'h2, 1'b1, 32'h4004, 1'b0, 32'h0);
    repeat (1500) @(posedge clk);
    chk("earlyReply", 32'h0, rq.size());
    busStatus[2] <= 1'b1;
    rep;
    chk("timeoutBit", 32'h0, r[14]);
    done;
    tmo(1'b1, 2, 1'b0, 0);
    busStatus <= 16'h0;
    bq.delete();
    cmd(3'h3, 1'b0, 32'h0, 1'b0, 32'h0);
    n = 1 + ($random(seed) & 3);
    repeat (n) begin
      b = 8'($random(seed));
      if (b == 8'h0d) b = 8'h0e;
      sq.push_back(b);
      hb(b);
    end
    hb(8'h0d);
    done;
    chk("wrtCount", sq.size(), wrtCount);
    foreach (sq[i]) chk("busByte", sq[i], bq[i]);
    bq.delete();
    cmd(3'h3, 1'b1, 32'd3, 1'b0, 32'h0);
    hb(8'h41);
    while (bq.size() == 0) @(posedge clk);
    hold <= 1'b1;
    hb(8'h42);
    hb(8'h43);
    done;
    hold <= 1'b0;
    chk("ioAbort", 32'h1, nAb);
    chk("errCode", 32'h6, errCode);
    chk("wrtCount", 32'h1, wrtCount);
    chk("busByte", 32'h41, bq[0]);
    cmd(3'h4, 1'b1, 32'h1, 1'b0, 32'h0);
    done;
    chk("spError", 32'h1, nSp);
    chk("errCode", 32'h6, errCode);
    cmd(3'h4, 1'b0, 32'h0, 1'b0, 32'h0);
    spResp <= 1'b1;
    @(posedge clk);
    spResp <= 1'b0;
    done;
    chk("spError", 32'h1, nSp);
    chk("errCode", 32'h0, errCode);
    statCont <= 1'b1;
    statNum <= 1'b1;
    statSym <= 1'b1;
    busStatus <= 16'($random(seed)) & 16'h0f00;
    tmo(1'b1, 2, 1'b1, 2);
    rep;
    chk("replyKind", 32'h0, r[17:16]);
    chk("replyStatus", {2'b00, busStatus[13:0]}, r[15:0]);
    rep;
    chk("replyKind", 32'h1, r[17:16]);
    statCont <= 1'b0;
    chk("limIo", 32'h2, limIo);
    cmd(3'h5, 1'b0, 32'h0, 1'b0, 32'h0);
    done;
    chk("limIo", 32'd1000000, limIo);
    chk("limSp", 32'd10000, limSp);
    chk("renOut", 32'h0, renOut);
    tmo(1'b1, 5, 1'b1, 5);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    chk("limIo", 32'd1000000, limIo);
    chk("limSp", 32'd10000, limSp);
    sysCtrlEnable <= 1'b0;
    n = nIfc;
    t0 = nTrg;
    cmd(3'h1, 1'b0, 32'h0, 1'b0, 32'h0);
    done;
    chk("ifcOut", n, nIfc);
    chk("trgReq", 32'h1, nTrg > t0);
    statCont <= 1'b1;
    statNum <= 1'b0;
    cmd(3'h6, 1'b0, 32'h0, 1'b0, 32'h0);
    rep;
    chk("replyKind", 32'h1, r[17:16]);
    chk("replyStatus", {2'b00, busStatus[13:0]}, r[15:0]);
    done;
    chk("errCode", 32'h0, errCode);
    completeRun();
  end
endmodule // testbench
